// ---- logic/rsfs_pkg.sv ----
// Constants, state encoding and register map of the startup and fault sequencer.
// Assumes a 25 MHz ref_clk; switching cycles are enable pulses derived from it.
package rsfs_pkg;
    localparam int CLK_KHZ = 25000;
    localparam int SW_FAST_KHZ = 500;
    localparam int SW_SLOW_KHZ = 300;
    // Divider reload values, one switching cycle each
    localparam logic [6:0] DIV_FAST = 7'(CLK_KHZ / SW_FAST_KHZ - 1);
    localparam logic [6:0] DIV_SLOW = 7'(CLK_KHZ / SW_SLOW_KHZ - 1);
    // Fallback reload while following sync, longer than any legal sync period
    localparam logic [6:0] DIV_EXT_WAIT = 7'h7F;
    // Soft-start interval range in microseconds, counted in fast switching cycles
    localparam int SS_MIN_US = 2600;
    localparam int SS_MAX_US = 214000;
    localparam logic [17:0] SS_LEN_MIN = 18'(SS_MIN_US * SW_FAST_KHZ / 1000);
    localparam logic [17:0] SS_LEN_MAX = 18'(SS_MAX_US * SW_FAST_KHZ / 1000);
    localparam logic [17:0] DISCH_TICKS = 18'h00100;
    localparam logic [17:0] HICCUP_TICKS = 18'h00200;
    localparam logic [2:0] FAULT_OVF = 3'h4;
    localparam logic [2:0] OC_FIRST = 3'h1;
    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_HICCUPS = 12'h008;
    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_OC_LSB = 4;
    localparam int ST_UV_LSB = 8;
    localparam int ST_PG_BIT = 12;
    localparam int ST_EXT_BIT = 13;
    localparam int ST_OVH_BIT = 14;
    localparam int ST_UVH_BIT = 15;
    localparam int SYNC_W = 15;

    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_DISCHARGE,
        ST_SOFTSTART,
        ST_RUN,
        ST_HICCUP
    } rsfs_mode_t;

    typedef struct packed {
        rsfs_mode_t mode;
        logic [2:0] ocCnt;
        logic [2:0] uvCnt;
        logic [17:0] timer;
        logic [6:0] divCnt;
        logic ovHold;
        logic underHold;
        logic pgRel;
        logic extSel;
        logic syncPrev;
        logic ocCut;
        logic [17:0] ssLen;
        logic [15:0] hiccups;
        logic [31:0] prdata;
    } rsfs_state_t;

    localparam rsfs_state_t STATE_RST = '{mode: ST_SHUTDOWN, ssLen: SS_LEN_MIN, default: '0};
endpackage

// ---- logic/rsfs_sync.sv ----
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not kept coherent with each other.
`timescale 1ns/1ns
module rsfs_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ---- logic/rsfs_top.sv ----
// Startup, power-good and hiccup fault sequencer of a switching regulator, with an APB slave.
// Assumes comparator and pin inputs are asynchronous levels; APB is on ref_clk.
// Notes on behaviour
// - No soft-start until bias threshold is met
// - Start soft-start once enable and bias hold
// - Reference follows ramp; interval 2.6 to 214ms
// - Power-good releases at ramp top and near setpoint
// - Losing enable or bias discharges ramp 256 cycles
// - Enable low pulls power-good low without clock
// - Internal oscillator until startup done and good
// - Phase-align to sync; sync optional before start
// - Select decode: 10, 4, 2 or none blocks
// - Overcurrent kills upper switches for the cycle
// - Overcurrent counter: set, advance, clear below limit
// - Four overcurrent detections shut down, power-good low
// - After overcurrent: clear, wait 512 plus ramp
// - Retries need overflow again, repeat forever
// - Power-good low above 111% until 107.5%
// - Power-good low below 89% until 92.5%
// - Undervoltage counter advances at 75%, clears with hysteresis
// - Four undervoltage detections shut down, power-good low
// - After undervoltage: clear, wait 512 plus ramp
// - Undervoltage retries need overflow again, repeat
// - Enable low: shutdown, all switches high impedance
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
module rsfs_top
    import rsfs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins
    input wire logic enablePin,
    input wire logic input_supply_ok,
    input wire logic frequency_select,
    input wire logic syncClkPin,
    input wire logic block_select_a,
    input wire logic block_select_b,
    // Comparators and ramp status
    input wire logic excess_current,
    input wire logic rampAtRef,
    input wire logic outNearSet,
    input wire logic fbAbove111,
    input wire logic fbAbove1075,
    input wire logic fbBelow89,
    input wire logic fbBelow925,
    input wire logic fbBelow75,
    input wire logic fbAbove785,
    // Open-drain power good
    output logic power_good_output,
    output logic powerGoodOe,
    // Power stage control
    output logic upperSwitchOff,
    output logic switchHiZ,
    output logic [9:0] blockEnable,
    output logic refFollowsRamp,
    output logic rampDischarge,
    output logic extClkSel
);
    rsfs_state_t s_q;
    rsfs_state_t s_d;
    logic [SYNC_W-1:0] pinsRaw;
    logic [SYNC_W-1:0] pins;
    logic enS, biasS, fselS, syncS, selAS, selBS, ocS, rampS, nearS;
    logic ovSetS, ovKeepS, unSetS, unKeepS, uvTripS, uvClearS;
    logic swTick, syncRise, powerOn, ocOvf, uvOvf;
    logic apbAccess;

    assign pinsRaw = {enablePin, input_supply_ok, frequency_select, syncClkPin,
                      block_select_a, block_select_b, excess_current, rampAtRef, outNearSet,
                      fbAbove111, fbAbove1075, fbBelow89, fbBelow925, fbBelow75, fbAbove785};

    rsfs_sync #(.WIDTH(SYNC_W)) u_sync
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(pinsRaw),
        .dout(pins)
    );

    assign {enS, biasS, fselS, syncS, selAS, selBS, ocS, rampS, nearS,
            ovSetS, ovKeepS, unSetS, unKeepS, uvTripS, uvClearS} = pins;

    assign swTick = (s_q.divCnt == 7'h00);
    assign syncRise = syncS & ~s_q.syncPrev;
    assign powerOn = (s_q.mode == ST_SOFTSTART) || (s_q.mode == ST_RUN);
    assign ocOvf = swTick && ocS && (s_q.ocCnt == FAULT_OVF - OC_FIRST);
    assign uvOvf = swTick && uvTripS && (s_q.uvCnt == FAULT_OVF - OC_FIRST);
    assign apbAccess = psel && penable;

    always_comb
    begin
        s_d = s_q;
        s_d.syncPrev = syncS;
        // Divider: reload per selected frequency; a sync edge restarts the cycle in phase
        // Under sync the divider only covers a missing edge, so no short extra cycle appears
        if (s_q.extSel && syncRise)
            s_d.divCnt = 7'h00;
        else if (swTick)
            s_d.divCnt = s_q.extSel ? DIV_EXT_WAIT : (fselS ? DIV_SLOW : DIV_FAST);
        else
            s_d.divCnt = s_q.divCnt - 7'h01;
        // Cut upper switches for the rest of the cycle on overcurrent
        if (swTick)
            s_d.ocCut = 1'b0;
        if (ocS && powerOn)
            s_d.ocCut = 1'b1;
        // Window hysteresis for power good
        if (ovSetS)
            s_d.ovHold = 1'b1;
        else if (!ovKeepS)
            s_d.ovHold = 1'b0;
        if (unSetS)
            s_d.underHold = 1'b1;
        else if (!unKeepS)
            s_d.underHold = 1'b0;
        // Fault counters sampled once per switching cycle, kept apart
        if (swTick && powerOn)
        begin
            if (ocS)
                s_d.ocCnt = (s_q.ocCnt == FAULT_OVF) ? FAULT_OVF : s_q.ocCnt + 3'h1;
            else
                s_d.ocCnt = 3'h0;
            if (uvTripS)
                s_d.uvCnt = (s_q.uvCnt == FAULT_OVF) ? FAULT_OVF : s_q.uvCnt + 3'h1;
            else if (uvClearS)
                s_d.uvCnt = 3'h0;
        end
        if (swTick && s_q.timer != 18'h00000)
            s_d.timer = s_q.timer - 18'h00001;
        case (s_q.mode)
            ST_SHUTDOWN:
            begin
                s_d.pgRel = 1'b0;
                s_d.extSel = 1'b0;
                if (enS && biasS)
                    s_d.mode = ST_SOFTSTART;
            end
            ST_DISCHARGE:
            begin
                s_d.pgRel = 1'b0;
                s_d.extSel = 1'b0;
                if (swTick && s_q.timer == 18'h00000)
                    s_d.mode = ST_SHUTDOWN;
            end
            ST_SOFTSTART:
            begin
                // Oscillator stays internal during the ramp
                s_d.extSel = 1'b0;
                if (ocOvf || uvOvf)
                    s_d.pgRel = 1'b0;
                else if (rampS && nearS && !s_d.ovHold && !s_d.underHold)
                begin
                    s_d.mode = ST_RUN;
                    s_d.pgRel = 1'b1;
                end
            end
            ST_RUN:
            begin
                s_d.pgRel = !s_d.ovHold && !s_d.underHold;
                if (s_q.pgRel)
                    s_d.extSel = 1'b1;
            end
            ST_HICCUP:
            begin
                s_d.pgRel = 1'b0;
                s_d.extSel = 1'b0;
                s_d.ocCnt = 3'h0;
                s_d.uvCnt = 3'h0;
                if (swTick && s_q.timer == 18'h00000)
                    s_d.mode = ST_SOFTSTART;
            end
            default:
            begin
                s_d.mode = ST_SHUTDOWN;
            end
        endcase
        // Fault overflow ends the current attempt, forever retrying
        if (powerOn && (ocOvf || uvOvf))
        begin
            s_d.mode = ST_HICCUP;
            s_d.pgRel = 1'b0;
            s_d.extSel = 1'b0;
            s_d.ocCnt = 3'h0;
            s_d.uvCnt = 3'h0;
            s_d.timer = HICCUP_TICKS + s_q.ssLen - 18'h00001;
            s_d.hiccups = s_q.hiccups + 16'h0001;
        end
        // Losing enable or bias overrides everything else
        if ((!enS || !biasS) && s_q.mode != ST_SHUTDOWN && s_q.mode != ST_DISCHARGE)
        begin
            s_d.mode = ST_DISCHARGE;
            s_d.timer = DISCH_TICKS - 18'h00001;
            s_d.pgRel = 1'b0;
            s_d.extSel = 1'b0;
            s_d.ocCnt = 3'h0;
            s_d.uvCnt = 3'h0;
        end
        // APB: zero wait state; reads register data for the access phase
        s_d.prdata = 32'h00000000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL: s_d.prdata = {14'h0000, s_q.ssLen};
                ADDR_STATUS:
                begin
                    s_d.prdata[ST_STATE_LSB +: 3] = s_q.mode;
                    s_d.prdata[ST_OC_LSB +: 3] = s_q.ocCnt;
                    s_d.prdata[ST_UV_LSB +: 3] = s_q.uvCnt;
                    s_d.prdata[ST_PG_BIT] = s_q.pgRel;
                    s_d.prdata[ST_EXT_BIT] = s_q.extSel;
                    s_d.prdata[ST_OVH_BIT] = s_q.ovHold;
                    s_d.prdata[ST_UVH_BIT] = s_q.underHold;
                end
                ADDR_HICCUPS: s_d.prdata = {16'h0000, s_q.hiccups};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
        else if (apbAccess)
            s_d.prdata = s_q.prdata;
        if (apbAccess && pwrite && paddr == ADDR_CTRL)
        begin
            // Clamp keeps the retry delay inside the ramp range the capacitor can give
            if (pwdata[17:0] < SS_LEN_MIN)
                s_d.ssLen = SS_LEN_MIN;
            else if (pwdata[17:0] > SS_LEN_MAX)
                s_d.ssLen = SS_LEN_MAX;
            else
                s_d.ssLen = pwdata[17:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_q <= STATE_RST;
        else
            s_q <= s_d;
    end

    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign pslverr = apbAccess && !(paddr == ADDR_CTRL || (!pwrite && (paddr == ADDR_STATUS ||
                     paddr == ADDR_HICCUPS)));

    // Raw enable gates the pull-down so power good falls with no clock running
    assign power_good_output = 1'b0;
    assign powerGoodOe = !enablePin || !s_q.pgRel;
    assign extClkSel = s_q.extSel;
    assign refFollowsRamp = (s_q.mode == ST_SOFTSTART);
    assign rampDischarge = (s_q.mode == ST_DISCHARGE) || (s_q.mode == ST_HICCUP);
    assign switchHiZ = !powerOn || (selAS && selBS);
    // Raw comparator path: turn-off cannot wait for the synchroniser
    assign upperSwitchOff = excess_current || s_q.ocCut || switchHiZ;

    always_comb
    begin
        case ({selAS, selBS})
            2'b00: blockEnable = 10'h3FF;
            2'b01: blockEnable = 10'h00F;
            2'b10: blockEnable = 10'h003;
            default: blockEnable = 10'h000;
        endcase
        if (!powerOn)
            blockEnable = 10'h000;
    end

    sequence sHiccupEnd;
        s_q.mode == ST_HICCUP && swTick && s_q.timer == 18'h00000;
    endsequence

    sequence sDischEnter;
        s_q.mode != ST_DISCHARGE ##1 s_q.mode == ST_DISCHARGE;
    endsequence

    a_bias_gate: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.mode == ST_SHUTDOWN && !biasS |=> s_q.mode != ST_SOFTSTART)
        else $error("soft-start without bias");
    a_start_both: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.mode == ST_SHUTDOWN && enS && biasS |=> s_q.mode == ST_SOFTSTART)
        else $error("soft-start not begun");
    a_pg_cause: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.pgRel) && $past(s_q.mode) == ST_SOFTSTART |-> $past(rampS && nearS))
        else $error("power good released early");
    a_disch_len: assert property (@(posedge ref_clk) disable iff (rst)
        sDischEnter |-> s_q.timer == DISCH_TICKS - 18'h00001)
        else $error("discharge length wrong");
    a_pg_async: assert property (@(posedge ref_clk) disable iff (rst)
        !enablePin |-> powerGoodOe)
        else $error("power good not pulled low");
    a_ext_late: assert property (@(posedge ref_clk) disable iff (rst)
        extClkSel |-> s_q.mode == ST_RUN && ($past(extClkSel) || $past(s_q.pgRel)))
        else $error("external clock before startup done");
    a_sel_none: assert property (@(posedge ref_clk) disable iff (rst)
        selAS && selBS |-> blockEnable == 10'h000 && switchHiZ)
        else $error("blocks active with none selected");
    a_upper_off: assert property (@(posedge ref_clk) disable iff (rst)
        ocS && powerOn && !swTick |=> upperSwitchOff until_with swTick)
        else $error("upper switch back on in cycle");
    a_oc_ovf: assert property (@(posedge ref_clk) disable iff (rst)
        powerOn && ocOvf && enS && biasS |=> s_q.mode == ST_HICCUP && !s_q.pgRel)
        else $error("overcurrent overflow ignored");
    a_uv_ovf: assert property (@(posedge ref_clk) disable iff (rst)
        powerOn && uvOvf && enS && biasS |=> s_q.mode == ST_HICCUP && s_q.uvCnt == 3'h0)
        else $error("undervoltage overflow ignored");
    a_retry_start: assert property (@(posedge ref_clk) disable iff (rst)
        sHiccupEnd and (enS && biasS) |=> s_q.mode == ST_SOFTSTART)
        else $error("retry soft-start missing");
    a_ov_hold: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ovHold && ovKeepS |=> !s_q.pgRel)
        else $error("power good during overvoltage");
    a_oc_count: assert property (@(posedge ref_clk) disable iff (rst)
        swTick && powerOn && !ocS && enS && biasS |=> s_q.ocCnt == 3'h0)
        else $error("overcurrent counter not cleared");
    a_ext_phase: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.extSel && syncRise |=> swTick)
        else $error("switching cycle not aligned to sync");
    a_uv_clear: assert property (@(posedge ref_clk) disable iff (rst)
        swTick && powerOn && !uvTripS && uvClearS && enS && biasS |=> s_q.uvCnt == 3'h0)
        else $error("undervoltage counter not cleared");
    a_under_hold: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.underHold && unKeepS |=> !s_q.pgRel)
        else $error("power good during undervoltage");
    a_disch_done: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.mode == ST_DISCHARGE && swTick && s_q.timer == 18'h00000 |=> s_q.mode == ST_SHUTDOWN)
        else $error("discharge did not end");
    a_int_start: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.mode == ST_SOFTSTART |-> !extClkSel)
        else $error("external clock during soft-start");
endmodule

// ---- test/rsfs_sys_model.sv ----
// System-side model: drives enable, bias, select, frequency and sync pins.
// Assumes the bench commands it through levels; pins change just after ref_clk edges.
`timescale 1ns/1ns
module rsfs_sys_model
(
    // Clock and commands
    input wire logic ref_clk,
    input wire logic enReq,
    input wire logic biasReq,
    input wire logic [1:0] selReq,
    input wire logic syncRun,
    input wire logic fselReq,
    // Pins toward the sequencer
    output logic enablePin,
    output logic input_supply_ok,
    output logic frequency_select,
    output logic syncClkPin,
    output logic block_select_a,
    output logic block_select_b
);
    logic [5:0] syncCnt = 6'h00;

    always @(posedge ref_clk)
    begin
        enablePin <= enReq;
        input_supply_ok <= biasReq;
        frequency_select <= fselReq;
        {block_select_a, block_select_b} <= selReq;
        syncCnt <= (syncCnt == 6'h1A) ? 6'h00 : syncCnt + 6'h01;
        // Sync held low when absent, as a grounded pin would be; no 300 kHz sync is modelled
        if (!syncRun || fselReq)
        begin
            syncClkPin <= 1'b0;
        end
        else if (syncCnt == 6'h1A)
        begin
            // 54-cycle period is about 463 kHz, inside the band around 500 kHz
            syncClkPin <= !syncClkPin;
        end
    end
endmodule

// ---- test/rsfs_top_tb_top.sv ----
// Self-checking bench of the startup and fault sequencer: APB tasks and pin scenarios.
// Assumes the system model drives control pins; comparator levels are driven here.
`timescale 1ns/1ns
module rsfs_top_tb_top
    import rsfs_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic enReq = 1'b0, biasReq = 1'b0, syncRun = 1'b0, fselReq = 1'b0;
    logic [1:0] selReq = 2'h0;
    logic enablePin, input_supply_ok, frequency_select, syncClkPin, block_select_a, block_select_b;
    logic excess_current = 1'b0, rampAtRef = 1'b0, outNearSet = 1'b0;
    logic fbAbove111 = 1'b0, fbAbove1075 = 1'b0, fbBelow89 = 1'b0, fbBelow925 = 1'b0;
    logic fbBelow75 = 1'b0, fbAbove785 = 1'b1;
    logic power_good_output, powerGoodOe, upperSwitchOff, switchHiZ, refFollowsRamp, rampDischarge, extClkSel;
    logic [9:0] blockEnable;
    logic [31:0] rd;
    logic err;
    logic [31:0] wrVals [4] = '{32'h00000001, 32'h0003FFFF, 32'h000007D0, 32'h00000514};
    logic [31:0] wrExp [4] = '{32'h00000514, 32'h0001A1F8, 32'h000007D0, 32'h00000514};
    logic [9:0] blkExp [4] = '{10'h3FF, 10'h00F, 10'h003, 10'h000};
    int mismatches = 0;
    int checkCount = 0;
    int cycles = 0;

    always #20 ref_clk = !ref_clk;

    rsfs_sys_model sys (.ref_clk(ref_clk), .enReq(enReq), .biasReq(biasReq), .selReq(selReq), .syncRun(syncRun),
        .fselReq(fselReq),
        .enablePin(enablePin), .input_supply_ok(input_supply_ok), .frequency_select(frequency_select),
        .syncClkPin(syncClkPin), .block_select_a(block_select_a), .block_select_b(block_select_b));

    rsfs_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enablePin(enablePin),
        .input_supply_ok(input_supply_ok), .frequency_select(frequency_select), .syncClkPin(syncClkPin),
        .block_select_a(block_select_a), .block_select_b(block_select_b), .excess_current(excess_current),
        .rampAtRef(rampAtRef), .outNearSet(outNearSet), .fbAbove111(fbAbove111), .fbAbove1075(fbAbove1075),
        .fbBelow89(fbBelow89), .fbBelow925(fbBelow925), .fbBelow75(fbBelow75), .fbAbove785(fbAbove785),
        .power_good_output(power_good_output), .powerGoodOe(powerGoodOe), .upperSwitchOff(upperSwitchOff),
        .switchHiZ(switchHiZ), .blockEnable(blockEnable), .refFollowsRamp(refFollowsRamp),
        .rampDischarge(rampDischarge), .extClkSel(extClkSel));

    task automatic endOfTest();
        $display("Comparisons %0d, mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkBit(input string what, input logic exp, input logic got);
        check(what, {31'h0, exp}, {31'h0, got});
    endtask

    // Setup then access; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        checkBit("pready", 1'b1, pready);
    endtask

    task automatic rdStat();
        apb(1'b0, ADDR_STATUS, 32'h00000000);
    endtask

    task automatic ticks(input int n);
        repeat (n * 50) @(posedge ref_clk);
    endtask

    task automatic waitStatus(input string what, input logic [31:0] mask, input logic [31:0] val, input int tries);
        int n = 0;
        do
        begin
            rdStat();
            n++;
        end
        while ((rd & mask) !== val && n < tries);
        check(what, val, rd & mask);
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 130000)
        begin
            mismatches++;
            endOfTest();
        end
    end

    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ADDR_CTRL, wrVals[i]);
            apb(1'b0, ADDR_CTRL, 32'h00000000);
            check("ctrl interval", wrExp[i], rd);
        end
        apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
        checkBit("status write refused", 1'b1, err);
        apb(1'b0, 12'h00C, 32'h00000000);
        checkBit("unmapped refused", 1'b1, err);
        // Bias withheld: enable alone must not start the ramp
        syncRun <= 1'b1;
        enReq <= 1'b1;
        ticks(10);
        rdStat();
        check("held in shutdown", 32'h0, rd & 32'h7);
        checkBit("ramp ref idle", 1'b0, refFollowsRamp);
        biasReq <= 1'b1;
        waitStatus("soft-start", 32'h7, 32'h2, 8);
        checkBit("ref follows ramp", 1'b1, refFollowsRamp);
        checkBit("internal clock", 1'b0, extClkSel);
        rampAtRef <= 1'b1;
        ticks(3);
        rdStat();
        check("no release off setpoint", 32'h2, rd & 32'h1007);
        outNearSet <= 1'b1;
        waitStatus("run", 32'h1007, 32'h1003, 60);
        checkBit("pg released", 1'b0, powerGoodOe);
        ticks(3);
        checkBit("external clock", 1'b1, extClkSel);
        for (int i = 0; i < 4; i++)
        begin
            selReq <= 2'(i);
            ticks(2);
            check("block enable", {22'h0, blkExp[i]}, {22'h0, blockEnable});
            checkBit("tri-state", i == 3, switchHiZ);
        end
        selReq <= 2'h0;
        for (int j = 0; j < 2; j++)
        begin
            {fbAbove111, fbAbove1075, fbBelow89, fbBelow925} <= j ? 4'h3 : 4'hC;
            ticks(2);
            checkBit("pg window trip", 1'b1, powerGoodOe);
            {fbAbove111, fbAbove1075, fbBelow89, fbBelow925} <= j ? 4'h1 : 4'h4;
            ticks(2);
            checkBit("pg window hold", 1'b1, powerGoodOe);
            {fbAbove111, fbAbove1075, fbBelow89, fbBelow925} <= 4'h0;
            ticks(2);
            checkBit("pg window release", 1'b0, powerGoodOe);
        end
        excess_current <= 1'b1;
        waitStatus("oc first", 32'h70, 32'h10, 40);
        waitStatus("oc third", 32'h70, 32'h30, 60);
        check("uv untouched", 32'h0, rd & 32'h700);
        excess_current <= 1'b0;
        ticks(3);
        rdStat();
        check("oc cleared", 32'h3, rd & 32'h77);
        {fbBelow75, fbAbove785} <= 2'h2;
        waitStatus("uv first", 32'h700, 32'h100, 40);
        waitStatus("uv second", 32'h700, 32'h200, 40);
        check("oc untouched", 32'h0, rd & 32'h70);
        fbBelow75 <= 1'b0;
        ticks(3);
        rdStat();
        check("uv hold", 32'h203, rd & 32'h707);
        fbAbove785 <= 1'b1;
        ticks(3);
        rdStat();
        check("uv cleared", 32'h3, rd & 32'h707);
        {fbBelow75, fbAbove785} <= 2'h2;
        waitStatus("uv shutdown", 32'h7, 32'h4, 120);
        checkBit("uv pg low", 1'b1, powerGoodOe);
        check("counters cleared", 32'h0, rd & 32'h770);
        apb(1'b0, ADDR_HICCUPS, 32'h00000000);
        check("fault count", 32'h1, rd);
        // Second reset in mid-run, from the delay interval
        {fbBelow75, fbAbove785} <= 2'h1;
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        waitStatus("restart", 32'h7, 32'h3, 80);
        enReq <= 1'b0;
        @(posedge ref_clk);
        #1;
        checkBit("pg low at once", 1'b1, powerGoodOe);
        checkBit("pg data low", 1'b0, power_good_output);
        ticks(2);
        rdStat();
        check("discharge", 32'h1, rd & 32'h7);
        checkBit("ramp discharge", 1'b1, rampDischarge);
        checkBit("switches off", 1'b1, switchHiZ);
        ticks(240);
        rdStat();
        check("discharge length", 32'h1, rd & 32'h7);
        waitStatus("discharge end", 32'h7, 32'h0, 400);
        checkBit("shutdown hi-z", 1'b1, switchHiZ);
        enReq <= 1'b1;
        waitStatus("run again", 32'h7, 32'h3, 200);
        checkBit("upper on", 1'b0, upperSwitchOff);
        excess_current <= 1'b1;
        #1;
        checkBit("upper off at once", 1'b1, upperSwitchOff);
        waitStatus("oc shutdown", 32'h7, 32'h4, 200);
        checkBit("oc pg low", 1'b1, powerGoodOe);
        check("oc counter cleared", 32'h0, rd & 32'h70);
        excess_current <= 1'b0;
        rampAtRef <= 1'b0;
        outNearSet <= 1'b0;
        ticks(1700);
        rdStat();
        check("delay interval", 32'h4, rd & 32'h7);
        waitStatus("retry soft-start", 32'h7, 32'h2, 3000);
        excess_current <= 1'b1;
        waitStatus("retry oc two", 32'h70, 32'h20, 80);
        excess_current <= 1'b0;
        ticks(3);
        rdStat();
        check("retry continues", 32'h2, rd & 32'h77);
        apb(1'b0, ADDR_HICCUPS, 32'h00000000);
        check("fault count after reset", 32'h1, rd);
        // 300 kHz: counter steps about 83 cycles apart, so still one after 60
        fselReq <= 1'b1;
        ticks(3);
        excess_current <= 1'b1;
        waitStatus("slow oc first", 32'h70, 32'h10, 40);
        repeat (60) @(posedge ref_clk);
        rdStat();
        check("slow tick", 32'h12, rd & 32'h77);
        endOfTest();
    end
endmodule
